// ===== bsp_host_model.sv
// Purpose: host controller model driving link commands and collecting read words
// Assumes: called just after a true input clock rise
// Notes: released lines toggle each cycle so stale values are never mistaken for data
`timescale 1ns/1ps
module bsp_host_model (
  input wire logic k_clk_i,
  input wire logic [17:0] rd_data_i,
  input wire logic rd_oe_i,
  output logic load_n_o,
  output logic rw_o,
  output logic [3:0] addr_o,
  output logic [17:0] din_o,
  output logic [1:0] bw_n_o,
  output logic c_clk_o,
  output logic c_clk_n_o
);
  logic [17:0] q[$];
  logic [17:0] wd0 = 18'h0, wd1 = 18'h0, h1 = 18'h0;
  logic [1:0] wb0 = 2'h3, wb1 = 2'h3, hb1 = 2'h3;
  logic ph = 1'b0;
  initial begin
    load_n_o = 1'b1;
    rw_o = 1'b0;
    addr_o = 4'h0;
    din_o = 18'h0;
    bw_n_o = 2'h3;
  end
  assign c_clk_o = 1'b1;
  assign c_clk_n_o = 1'b1;
  always @(posedge k_clk_i) begin
    ph <= !load_n_o && !rw_o;
    h1 <= wd1;
    hb1 <= wb1;
    if (!load_n_o && !rw_o) begin
      din_o <= wd0;
      bw_n_o <= wb0;
    end else begin
      din_o <= ~din_o;
      bw_n_o <= ~bw_n_o;
    end
  end
  always @(negedge k_clk_i) if (ph) begin
    din_o <= h1;
    bw_n_o <= hb1;
  end
  always @(k_clk_i) begin
    #2;
    if (rd_oe_i === 1'b1) q.push_back(rd_data_i);
  end
  task cmd(input logic rd, input logic [3:0] a, input logic [17:0] d0, input logic [17:0] d1,
           input logic [1:0] b0, input logic [1:0] b1);
    load_n_o <= 1'b0;
    rw_o <= rd;
    addr_o <= a;
    wd0 <= d0;
    wd1 <= d1;
    wb0 <= b0;
    wb1 <= b1;
    @(posedge k_clk_i);
  endtask : cmd
  task nop(input int n);
    repeat (n) begin
      load_n_o <= 1'b1;
      rw_o <= ~rw_o;
      addr_o <= ~addr_o;
      @(posedge k_clk_i);
    end
  endtask : nop
endmodule : bsp_host_model

// ===== bsp_pkg.sv
// Purpose: shared constants for the burst sram read/write port
// Assumes: system clock CLK_I at 25 MHz, registers on AXI4-Lite
// Notes: the link side runs on the true input clock; its falling edge stands for the complementary rise
// Operation
// - address, load strobe and read/write select sampled on true-clock rising edge only.
// - write data and byte selects sampled on both input clock rising edges.
// - read burst returns base address word first, then base address plus one.
// - read data outputs float 2.5 cycles after last read when idle or write follows; with pll bypassed the enable drops 2 cycles after.
// - read of the just-written address returns the written words, not stale array data.
// - bypass input low runs without pll, slow clocks allowed, timing unguaranteed.
// - with pll bypassed read latency is one clock cycle.
// - pll needs 20 us of running input clock before normal operation.
// - pll resets when the true input clock stays static for 30 ns.
// - output clock pair tied high makes the input clock pair the output reference.
package bsp_pkg;

  localparam int CLK_KHZ = 25000;

  // pll lock time, least time so rounded up
  localparam int LOCK_TIME_US = 20;
  localparam int LOCK_CYC = (LOCK_TIME_US * CLK_KHZ + 999) / 1000;

  // input clock static time before the pll resets, rounded up, at least one cycle
  localparam int K_STATIC_NS = 30;
  localparam int K_STATIC_RAW = (K_STATIC_NS * CLK_KHZ + 999999) / 1000000;
  localparam int K_STATIC_CYC = (K_STATIC_RAW < 1) ? 1 : K_STATIC_RAW;

  localparam int AXI_AW = 4;
  localparam logic [AXI_AW-1:0] REG_CTRL = 4'h0;
  localparam logic [AXI_AW-1:0] REG_STATUS = 4'h4;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int CTRL_HOLD_BIT = 0;
  localparam int ST_LOCKED_BIT = 0;
  localparam int ST_BYPASS_BIT = 1;
  localparam int ST_REFK_BIT = 2;
  localparam int ST_STATIC_BIT = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {LAT_ONE_HALF, LAT_ONE} bsp_read_latency_e;

endpackage : bsp_pkg

// ===== bsp_top.sv
// Purpose: device-side logic of a two-word-burst ddr sram port with separate read and write buses
// Assumes: K_CLK_I is the true input clock; its falling edge is taken as the complementary clock rise
// Notes: pll lock and clock-stop watch run on CLK_I; the array and data path run on K_CLK_I
`timescale 1ns/1ps

module bsp_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule : bsp_sync

module bsp_top #(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 18,
  parameter int BW_W = 2,
  parameter int LOCK_CYC = bsp_pkg::LOCK_CYC,
  parameter int STATIC_CYC = bsp_pkg::K_STATIC_CYC
) (
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic [bsp_pkg::AXI_AW-1:0] AXI_AWADDR_I,
  input wire logic AXI_AWVALID_I,
  output logic AXI_AWREADY_O,
  input wire logic [31:0] AXI_WDATA_I,
  input wire logic [3:0] AXI_WSTRB_I,
  input wire logic AXI_WVALID_I,
  output logic AXI_WREADY_O,
  output logic [1:0] AXI_BRESP_O,
  output logic AXI_BVALID_O,
  input wire logic AXI_BREADY_I,
  input wire logic [bsp_pkg::AXI_AW-1:0] AXI_ARADDR_I,
  input wire logic AXI_ARVALID_I,
  output logic AXI_ARREADY_O,
  output logic [31:0] AXI_RDATA_O,
  output logic [1:0] AXI_RRESP_O,
  output logic AXI_RVALID_O,
  input wire logic AXI_RREADY_I,
  input wire logic K_CLK_I,
  input wire logic C_CLK_I,
  input wire logic C_CLK_N_I,
  input wire logic PLL_ENABLE_I,
  input wire logic LOAD_STROBE_N_I,
  input wire logic READ_WRITE_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [DATA_W-1:0] DATA_IN_I,
  input wire logic [BW_W-1:0] BYTE_WRITE_SELECT_N_I,
  output logic [DATA_W-1:0] READ_DATA_O,
  output logic READ_DATA_OE_O,
  output logic ECHO_CLOCK_TRUE_O,
  output logic ECHO_CLOCK_COMP_O
);
  localparam int LANE_W = DATA_W / BW_W;
  localparam int LCW = $clog2(LOCK_CYC + 1);
  localparam int SCW = $clog2(STATIC_CYC + 1);
  localparam int DEPTH = 1 << ADDR_W;

  function automatic logic [DATA_W-1:0] merge_word(input logic [DATA_W-1:0] old_w,
                                                   input logic [DATA_W-1:0] new_w,
                                                   input logic [BW_W-1:0] sel_n);
    logic [DATA_W-1:0] res;
    res = old_w;
    for (int i = 0; i < BW_W; i++) begin
      if (!sel_n[i]) begin
        res[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
      end
    end
    return res;
  endfunction : merge_word

  function automatic logic [ADDR_W-1:0] burst_next(input logic [ADDR_W-1:0] a);
    return a + {{(ADDR_W-1){1'b0}}, 1'b1};
  endfunction : burst_next

  // ---- system clock side: pll model and clock-stop watch
  logic [1:0] k_gray_r;
  logic [1:0] k_gray_s;
  logic [1:0] k_gray_q_r;
  logic pll_en_s;
  logic ref_k_s;
  logic ref_k_r;
  logic [SCW-1:0] idle_cnt_r;
  logic [LCW-1:0] lock_cnt_r;
  logic locked_r;
  logic k_static;
  logic [31:0] ctrl_r;

  bsp_sync #(.W(4)) u_sync_clk (
    .clk_i(CLK_I),
    .rst_i(SRST_I),
    .d_i({k_gray_r, PLL_ENABLE_I, ref_k_r}),
    .q_o({k_gray_s, pll_en_s, ref_k_s})
  );

  // the watched counter is a 2-bit gray sequence so a sample never sees a false jump
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      k_gray_q_r <= '0;
      idle_cnt_r <= '0;
    end else begin
      k_gray_q_r <= k_gray_s;
      if (k_gray_s != k_gray_q_r) begin
        idle_cnt_r <= '0;
      end else if (idle_cnt_r < SCW'(STATIC_CYC)) begin
        idle_cnt_r <= idle_cnt_r + 1'b1;
      end
    end
  end

  assign k_static = (idle_cnt_r >= SCW'(STATIC_CYC));

  // lock restarts on a stopped clock, in bypass, or while software holds it
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      lock_cnt_r <= '0;
      locked_r <= 1'b0;
    end else if (!pll_en_s || k_static || ctrl_r[bsp_pkg::CTRL_HOLD_BIT]) begin
      lock_cnt_r <= '0;
      locked_r <= 1'b0;
    end else if (lock_cnt_r < LCW'(LOCK_CYC)) begin
      lock_cnt_r <= lock_cnt_r + 1'b1;
      locked_r <= 1'b0;
    end else begin
      locked_r <= 1'b1;
    end
  end

  // ---- AXI4-Lite slave
  logic aw_got_r;
  logic w_got_r;
  logic [bsp_pkg::AXI_AW-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [31:0] status;
  logic [1:0] wresp;

  assign status = {28'h0000000, k_static, ref_k_s, !pll_en_s, locked_r};
  assign AXI_AWREADY_O = !aw_got_r && !AXI_BVALID_O;
  assign AXI_WREADY_O = !w_got_r && !AXI_BVALID_O;
  assign AXI_ARREADY_O = !AXI_RVALID_O;
  assign wresp = (aw_addr_r == bsp_pkg::REG_CTRL || aw_addr_r == bsp_pkg::REG_STATUS) ?
                 bsp_pkg::RESP_OKAY : bsp_pkg::RESP_SLVERR;

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (aw_got_r && w_got_r) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
    end else begin
      if (AXI_AWVALID_I && AXI_AWREADY_O) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= AXI_AWADDR_I;
      end
      if (AXI_WVALID_I && AXI_WREADY_O) begin
        w_got_r <= 1'b1;
        w_data_r <= AXI_WDATA_I;
        w_strb_r <= AXI_WSTRB_I;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      ctrl_r <= bsp_pkg::CTRL_RST;
      AXI_BVALID_O <= 1'b0;
      AXI_BRESP_O <= bsp_pkg::RESP_OKAY;
    end else if (aw_got_r && w_got_r) begin
      AXI_BVALID_O <= 1'b1;
      AXI_BRESP_O <= wresp;
      if (aw_addr_r == bsp_pkg::REG_CTRL && w_strb_r[0]) begin
        ctrl_r[bsp_pkg::CTRL_HOLD_BIT] <= w_data_r[bsp_pkg::CTRL_HOLD_BIT];
      end
    end else if (AXI_BVALID_O && AXI_BREADY_I) begin
      AXI_BVALID_O <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      AXI_RVALID_O <= 1'b0;
      AXI_RDATA_O <= '0;
      AXI_RRESP_O <= bsp_pkg::RESP_OKAY;
    end else if (AXI_ARVALID_I && AXI_ARREADY_O) begin
      AXI_RVALID_O <= 1'b1;
      case (AXI_ARADDR_I)
        bsp_pkg::REG_CTRL: begin
          AXI_RDATA_O <= ctrl_r;
          AXI_RRESP_O <= bsp_pkg::RESP_OKAY;
        end
        bsp_pkg::REG_STATUS: begin
          AXI_RDATA_O <= status;
          AXI_RRESP_O <= bsp_pkg::RESP_OKAY;
        end
        default: begin
          AXI_RDATA_O <= '0;
          AXI_RRESP_O <= bsp_pkg::RESP_SLVERR;
        end
      endcase
    end else if (AXI_RVALID_O && AXI_RREADY_I) begin
      AXI_RVALID_O <= 1'b0;
    end
  end

  // ---- link side on the input clock
  logic k_rst;
  logic pll_en_k;
  logic locked_k;
  logic c_t_k;
  logic c_c_k;
  logic ready_k;
  logic rd_cmd;
  logic wr_cmd;
  logic out_clk;
  bsp_pkg::bsp_read_latency_e read_latency_r;
  logic [DATA_W-1:0] mem_r [DEPTH];
  logic wr_pend_r;
  logic [ADDR_W-1:0] wr_addr_r;
  logic [ADDR_W-1:0] wa1;
  logic [ADDR_W-1:0] ra1;
  logic [DATA_W-1:0] d0_r;
  logic [BW_W-1:0] bw0_r;
  logic [DATA_W-1:0] wm0;
  logic [DATA_W-1:0] wm1;
  logic [DATA_W-1:0] rw0;
  logic [DATA_W-1:0] rw1;
  logic s0_v_r;
  logic s1_v_r;
  logic [DATA_W-1:0] s0_w0_r;
  logic [DATA_W-1:0] s0_w1_r;
  logic [DATA_W-1:0] s1_w0_r;
  logic [DATA_W-1:0] s1_w1_r;
  logic [DATA_W-1:0] q_pos_r;
  logic [DATA_W-1:0] q_neg_r;
  logic oe_pos_r;
  logic oe_neg_r;

  // reset synchroniser itself has none; it settles after two input clock edges
  bsp_sync #(.W(1)) u_sync_rst (
    .clk_i(K_CLK_I),
    .rst_i(1'b0),
    .d_i(SRST_I),
    .q_o(k_rst)
  );

  bsp_sync #(.W(4)) u_sync_k (
    .clk_i(K_CLK_I),
    .rst_i(k_rst),
    .d_i({PLL_ENABLE_I, locked_r, C_CLK_I, C_CLK_N_I}),
    .q_o({pll_en_k, locked_k, c_t_k, c_c_k})
  );

  // commands are dropped until the pll is locked; in bypass they are taken at once
  assign ready_k = !pll_en_k || locked_k;
  assign rd_cmd = ready_k && !LOAD_STROBE_N_I && READ_WRITE_I;
  assign wr_cmd = ready_k && !LOAD_STROBE_N_I && !READ_WRITE_I;
  assign wa1 = burst_next(wr_addr_r);
  assign ra1 = burst_next(ADDR_I);

  always_ff @(posedge K_CLK_I) begin
    if (k_rst) begin
      k_gray_r <= '0;
      read_latency_r <= bsp_pkg::LAT_ONE_HALF;
      ref_k_r <= 1'b0;
    end else begin
      k_gray_r <= {k_gray_r[0], ~k_gray_r[1]};
      read_latency_r <= pll_en_k ? bsp_pkg::LAT_ONE_HALF : bsp_pkg::LAT_ONE;
      ref_k_r <= c_t_k && c_c_k;
    end
  end

  // first write word on the complementary rise of the command cycle, second on the next true rise
  always_ff @(posedge K_CLK_I) begin
    if (k_rst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end else begin
      wr_pend_r <= wr_cmd;
      if (wr_cmd) begin
        wr_addr_r <= ADDR_I;
      end
    end
  end

  always_ff @(negedge K_CLK_I) begin
    if (k_rst) begin
      d0_r <= '0;
      bw0_r <= '1;
    end else if (wr_pend_r) begin
      d0_r <= DATA_IN_I;
      bw0_r <= BYTE_WRITE_SELECT_N_I;
    end
  end

  assign wm0 = merge_word(mem_r[wr_addr_r], d0_r, bw0_r);
  assign wm1 = merge_word(mem_r[wa1], DATA_IN_I, BYTE_WRITE_SELECT_N_I);

  always_ff @(posedge K_CLK_I) begin
    if (wr_pend_r) begin
      mem_r[wr_addr_r] <= wm0;
      mem_r[wa1] <= wm1;
    end
  end

  // the array commits in the same edge the next read looks up, so a hit takes the merged words
  always_comb begin
    rw0 = mem_r[ADDR_I];
    rw1 = mem_r[ra1];
    if (wr_pend_r && ADDR_I == wa1) begin
      rw0 = wm1;
    end
    if (wr_pend_r && ADDR_I == wr_addr_r) begin
      rw0 = wm0;
    end
    if (wr_pend_r && ra1 == wa1) begin
      rw1 = wm1;
    end
    if (wr_pend_r && ra1 == wr_addr_r) begin
      rw1 = wm0;
    end
  end

  always_ff @(posedge K_CLK_I) begin
    if (k_rst) begin
      s0_v_r <= 1'b0;
      s1_v_r <= 1'b0;
      s0_w0_r <= '0;
      s0_w1_r <= '0;
      s1_w0_r <= '0;
      s1_w1_r <= '0;
    end else begin
      s0_v_r <= rd_cmd;
      if (rd_cmd) begin
        s0_w0_r <= rw0;
        s0_w1_r <= rw1;
      end
      s1_v_r <= s0_v_r;
      s1_w0_r <= s0_w0_r;
      s1_w1_r <= s0_w1_r;
    end
  end

  // pll mode: words on the complementary rise after the command cycle and the following true rise
  // bypass: words on the next true rise and the complementary rise after it
  always_ff @(posedge K_CLK_I) begin
    if (k_rst) begin
      q_pos_r <= '0;
      oe_pos_r <= 1'b0;
    end else if (read_latency_r == bsp_pkg::LAT_ONE) begin
      q_pos_r <= s0_w0_r;
      oe_pos_r <= s0_v_r;
    end else begin
      q_pos_r <= s1_w1_r;
      oe_pos_r <= s1_v_r;
    end
  end

  always_ff @(negedge K_CLK_I) begin
    if (k_rst) begin
      q_neg_r <= '0;
      oe_neg_r <= 1'b0;
    end else begin
      q_neg_r <= (read_latency_r == bsp_pkg::LAT_ONE) ? s1_w1_r : s1_w0_r;
      oe_neg_r <= s1_v_r;
    end
  end

  // with the output pair tied high the input clock times data and echo clocks
  assign out_clk = ref_k_r ? K_CLK_I : C_CLK_I;
  assign READ_DATA_O = out_clk ? q_pos_r : q_neg_r;
  assign READ_DATA_OE_O = out_clk ? oe_pos_r : oe_neg_r;
  assign ECHO_CLOCK_TRUE_O = out_clk;
  assign ECHO_CLOCK_COMP_O = !out_clk;

endmodule : bsp_top

// ===== bsp_top_properties.sv
// Purpose: port-level properties of the burst sram port
// Assumes: output clock pair held high, so the true input clock is the reference
// Notes: link properties sample on the true input clock rise
`timescale 1ns/1ps
module bsp_top_properties (
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic K_CLK_I,
  input wire logic AXI_AWVALID_I,
  input wire logic AXI_AWREADY_O,
  input wire logic AXI_WVALID_I,
  input wire logic AXI_WREADY_O,
  input wire logic AXI_BVALID_O,
  input wire logic AXI_BREADY_I,
  input wire logic [bsp_pkg::AXI_AW-1:0] AXI_ARADDR_I,
  input wire logic AXI_ARVALID_I,
  input wire logic AXI_ARREADY_O,
  input wire logic AXI_RVALID_O,
  input wire logic [1:0] AXI_RRESP_O,
  input wire logic LOAD_STROBE_N_I,
  input wire logic READ_WRITE_I,
  input wire logic READ_DATA_OE_O,
  input wire logic C_CLK_I,
  input wire logic C_CLK_N_I,
  input wire logic ECHO_CLOCK_TRUE_O,
  input wire logic ECHO_CLOCK_COMP_O
);
  logic rd_cmd;
  assign rd_cmd = !LOAD_STROBE_N_I && READ_WRITE_I;
  a_bvalid_hold: assert property (@(posedge CLK_I) disable iff (SRST_I)
    AXI_BVALID_O && !AXI_BREADY_I |=> AXI_BVALID_O) else $error("write response withdrawn");
  a_aw_block: assert property (@(posedge CLK_I) disable iff (SRST_I)
    AXI_BVALID_O |-> !AXI_AWREADY_O && !AXI_WREADY_O) else $error("write taken during response");
  a_ar_block: assert property (@(posedge CLK_I) disable iff (SRST_I)
    AXI_RVALID_O |-> !AXI_ARREADY_O) else $error("read taken during response");
  a_rd_answer: assert property (@(posedge CLK_I) disable iff (SRST_I)
    AXI_ARVALID_I && AXI_ARREADY_O |=> AXI_RVALID_O) else $error("read answer late");
  a_wr_answer: assert property (@(posedge CLK_I) disable iff (SRST_I)
    AXI_AWVALID_I && AXI_AWREADY_O && AXI_WVALID_I && AXI_WREADY_O |=> !AXI_BVALID_O ##1 AXI_BVALID_O)
    else $error("write answer not two cycles");
  a_rd_err: assert property (@(posedge CLK_I) disable iff (SRST_I)
    AXI_ARVALID_I && AXI_ARREADY_O && AXI_ARADDR_I != bsp_pkg::REG_CTRL && AXI_ARADDR_I != bsp_pkg::REG_STATUS
    |=> AXI_RRESP_O == bsp_pkg::RESP_SLVERR) else $error("unmapped read not refused");
  // the enable window is two edges behind its read in both latency modes
  a_oe_cause: assert property (@(posedge K_CLK_I) disable iff (SRST_I)
    READ_DATA_OE_O |-> $past(rd_cmd, 2)) else $error("read outputs driven without a read");
  // the reference choice is synchronised, so it reaches the echo pins several input clock edges after reset
  logic [2:0] settle_r;
  always_ff @(posedge K_CLK_I) begin
    if (SRST_I || !(C_CLK_I && C_CLK_N_I)) begin
      settle_r <= 3'h0;
    end else if (settle_r != 3'h6) begin
      settle_r <= settle_r + 3'h1;
    end
  end
  a_echo_ref: assert property (@(posedge K_CLK_I) disable iff (SRST_I)
    settle_r == 3'h6 && C_CLK_I && C_CLK_N_I |-> !ECHO_CLOCK_TRUE_O && ECHO_CLOCK_COMP_O)
    else $error("echo not on input clock");
endmodule : bsp_top_properties

// ===== bsp_top_tb_top.sv
// Purpose: self-checking bench for the burst sram port
// Assumes: lock count shortened to 8 system cycles
// Notes: read words are collected by the host model at every link edge
`timescale 1ns/1ps
module bsp_top_tb_top;
  localparam logic [17:0] D0 = 18'h12345, D1 = 18'h0abcd, D2 = 18'h3c0f1, D3 = 18'h00f3e;
  logic clk = 1'b0, k = 1'b0, k_run = 1'b1, srst = 1'b1, pll_en = 1'b1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, addr;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, oe, load_n, rw, c_hi, c_hi_n;
  logic [1:0] bresp, rresp, bw_n;
  logic [17:0] din, rdq;
  int error_cnt = 0, samples_checked = 0;
  initial forever #20 clk = ~clk;
  initial begin
    #3;
    forever begin
      #7.5;
      if (k_run) k = ~k;
    end
  end
  bsp_top #(.LOCK_CYC(8)) dut (
    .CLK_I(clk), .SRST_I(srst), .AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awvalid), .AXI_AWREADY_O(awready),
    .AXI_WDATA_I(wdata), .AXI_WSTRB_I(4'hf), .AXI_WVALID_I(wvalid), .AXI_WREADY_O(wready),
    .AXI_BRESP_O(bresp), .AXI_BVALID_O(bvalid), .AXI_BREADY_I(bready), .AXI_ARADDR_I(araddr),
    .AXI_ARVALID_I(arvalid), .AXI_ARREADY_O(arready), .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp),
    .AXI_RVALID_O(rvalid), .AXI_RREADY_I(rready), .K_CLK_I(k), .C_CLK_I(c_hi), .C_CLK_N_I(c_hi_n),
    .PLL_ENABLE_I(pll_en), .LOAD_STROBE_N_I(load_n), .READ_WRITE_I(rw), .ADDR_I(addr), .DATA_IN_I(din),
    .BYTE_WRITE_SELECT_N_I(bw_n), .READ_DATA_O(rdq), .READ_DATA_OE_O(oe), .ECHO_CLOCK_TRUE_O(),
    .ECHO_CLOCK_COMP_O());
  bsp_host_model host (.k_clk_i(k), .rd_data_i(rdq), .rd_oe_i(oe), .load_n_o(load_n), .rw_o(rw),
    .addr_o(addr), .din_o(din), .bw_n_o(bw_n), .c_clk_o(c_hi), .c_clk_n_o(c_hi_n));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task wrap_up;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(negedge clk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      r = bresp;
      @(posedge clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end while (!b);
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, b;
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do begin
      @(negedge clk);
      ar = arvalid && arready;
      b = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ar) arvalid <= 1'b0;
    end while (!b);
    rready <= 1'b0;
  endtask : axi_rd
  task automatic wait_lock;
    logic [31:0] d;
    logic [1:0] r;
    d = 32'h0;
    for (int i = 0; i < 40 && d[bsp_pkg::ST_LOCKED_BIT] !== 1'b1; i++) axi_rd(bsp_pkg::REG_STATUS, d, r);
    chk(d & 32'h1, 32'h1);
  endtask : wait_lock
  task automatic chk_rd(input logic [17:0] e0, input logic [17:0] e1, input logic [17:0] e2,
                        input logic [17:0] e3);
    chk(32'(host.q.size()), 32'h4);
    chk({14'h0, host.q[0]}, {14'h0, e0});
    chk({14'h0, host.q[1]}, {14'h0, e1});
    chk({14'h0, host.q[2]}, {14'h0, e2});
    chk({14'h0, host.q[3]}, {14'h0, e3});
  endtask : chk_rd
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge k);
    host.cmd(1'b1, 4'h0, D0, D0, 2'h3, 2'h3);
    host.nop(4);
    chk(32'(host.q.size()), 32'h0);
    axi_rd(bsp_pkg::REG_CTRL, d, r);
    chk(d, bsp_pkg::CTRL_RST);
    axi_wr(4'h8, 32'h1, r);
    chk({30'h0, r}, {30'h0, bsp_pkg::RESP_SLVERR});
    axi_rd(4'hc, d, r);
    chk({30'h0, r}, {30'h0, bsp_pkg::RESP_SLVERR});
    wait_lock;
    axi_wr(bsp_pkg::REG_CTRL, 32'h1, r);
    axi_rd(bsp_pkg::REG_STATUS, d, r);
    chk(d & 32'h1, 32'h0);
    axi_wr(bsp_pkg::REG_CTRL, 32'h0, r);
    wait_lock;
  endtask : t_regs
  // read at the wrap address, then a merged partial write read straight back
  task automatic t_burst;
    host.q.delete();
    @(posedge k);
    host.cmd(1'b0, 4'hf, D0, D1, 2'h0, 2'h0);
    host.cmd(1'b1, 4'hf, D0, D0, 2'h3, 2'h3);
    host.cmd(1'b0, 4'h4, D2, D3, 2'h0, 2'h0);
    host.cmd(1'b0, 4'h4, ~D2, ~D3, 2'h2, 2'h1);
    host.cmd(1'b1, 4'h4, D0, D0, 2'h3, 2'h3);
    host.nop(5);
    chk_rd(D0, D1, {D2[17:9], ~D2[8:0]}, {~D3[17:9], D3[8:0]});
  endtask : t_burst
  task automatic t_bypass;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    pll_en <= 1'b0;
    repeat (6) @(posedge k);
    axi_rd(bsp_pkg::REG_STATUS, d, r);
    chk(d & 32'h2, 32'h2);
    host.q.delete();
    @(posedge k);
    host.cmd(1'b1, 4'hf, D0, D0, 2'h3, 2'h3);
    host.cmd(1'b1, 4'h4, D0, D0, 2'h3, 2'h3);
    host.nop(4);
    chk_rd(D0, D1, {D2[17:9], ~D2[8:0]}, {~D3[17:9], D3[8:0]});
    @(posedge clk);
    pll_en <= 1'b1;
    wait_lock;
  endtask : t_bypass
  task automatic t_clk_stop;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    k_run <= 1'b0;
    repeat (6) @(posedge clk);
    axi_rd(bsp_pkg::REG_STATUS, d, r);
    chk(d & 32'h9, 32'h8);
    k_run <= 1'b1;
    wait_lock;
  endtask : t_clk_stop
  initial begin
    #100000;
    error_cnt++;
    wrap_up;
  end
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_regs;
    t_burst;
    t_bypass;
    t_clk_stop;
    wrap_up;
  end
endmodule : bsp_top_tb_top
bind bsp_top bsp_top_properties u_props (.*);
